// ===== hw/potc_top.sv
`timescale 1ns/1ps
// Function
// - enabled bit copies pattern on selected event
// - disabled bit never copies, output holds
// - enable bit n gates pattern bit n to port bit n
// - enable register clears on reset and standby
// - trigger select resets to all ones
// - select bits 7:6 pick group 3 channel
// - select bits 5:4 pick group 2 channel
// - select bits 3:2 pick group 1 channel
// - select bits 1:0 pick group 0 channel
// - overlap mode resets to f0
// - overlap mode upper bits read one, unwritable
// - mode bit zero: change on event A
// - mode bit one: non-overlapping A and B
// - non-overlap copies all enabled at A
// - non-overlap copies zeros only at B
// - capture event replaces compare when capturing
module potc_top (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        hw_standby,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire potc_pkg::potc_tmr_evt_type  tmr_evt [potc_pkg::NUM_CH],
  output logic      [7:0]                  port_b_output,
  output logic      [3:0]                  grp_trig_a,
  output logic      [3:0]                  grp_trig_b
);
  logic [7:0] next_enable_b_reg;
  logic [7:0] trigger_select_reg;
  logic [3:0] overlap_mode_reg;
  logic [7:0] next_pattern_b_reg;
  logic [7:0] port_b_output_reg;
  logic [7:0] port_b_output_next;
  logic [7:0] port_b_base;
  logic       hw_standby_s;
  potc_pkg::potc_apb_state_type state_reg;
  potc_pkg::potc_apb_state_type state_next;
  logic [31:0] prdata_next;
  logic        err_next;
  logic [3:0]  fire_a_all;
  logic [3:0]  fire_b_all;

  // standby is a pin level from outside, so it is synchronised first
  potc_sync2 #(.W(1)) u_stby (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (hw_standby),
    .q     (hw_standby_s)
  );

  // apb decode
  wire access_w   = psel && penable && (state_reg == potc_pkg::POTC_ACCESS);
  wire hit_en     = paddr == potc_pkg::ADDR_NEXT_ENABLE_B;
  wire hit_ts     = paddr == potc_pkg::ADDR_TRIGGER_SELECT;
  wire hit_om     = paddr == potc_pkg::ADDR_OVERLAP_MODE;
  wire hit_np     = paddr == potc_pkg::ADDR_NEXT_PATTERN_B;
  wire hit_po     = paddr == potc_pkg::ADDR_PORT_B_OUTPUT;
  wire mapped     = hit_en | hit_ts | hit_om | hit_np | hit_po;
  // a write lands only at the edge where the master sees pready high
  wire xfer_w     = psel && penable && pready;
  // byte lane 0 carries the 8-bit register
  wire wr_ok      = xfer_w && pwrite && pstrb[0] && mapped;
  wire wr_en      = wr_ok && hit_en;
  wire wr_ts      = wr_ok && hit_ts;
  wire wr_om      = wr_ok && hit_om;
  wire wr_np      = wr_ok && hit_np;
  wire wr_po      = wr_ok && hit_po;

  // software write is the base that timer copies then override bit by bit
  assign port_b_base = wr_po ? pwdata[7:0] : port_b_output_reg;

  // one wait state: setup, access (registered answer), done
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      potc_pkg::POTC_IDLE:   if (psel && !penable) state_next = potc_pkg::POTC_ACCESS;
      potc_pkg::POTC_ACCESS: if (psel && penable) state_next = potc_pkg::POTC_DONE;
      potc_pkg::POTC_DONE:   state_next = potc_pkg::POTC_IDLE;
      default:               state_next = potc_pkg::POTC_IDLE;
    endcase
  end

  // reserved mode bits always read as one
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (1'b1)
      hit_en:  prdata_next[7:0] = next_enable_b_reg;
      hit_ts:  prdata_next[7:0] = trigger_select_reg;
      hit_om:  prdata_next[7:0] = {potc_pkg::OVERLAP_RSVD_ONES, overlap_mode_reg};
      hit_np:  prdata_next[7:0] = next_pattern_b_reg;
      hit_po:  prdata_next[7:0] = port_b_output_reg;
      default: prdata_next = 32'h0000_0000;
    endcase
  end
  assign err_next = !mapped;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= potc_pkg::POTC_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      pready    <= access_w;
      pslverr   <= access_w && err_next;
      prdata    <= (access_w && !pwrite) ? prdata_next : 32'h0000_0000;
    end
  end

  // configuration registers; standby re-initialises, software standby does not reach here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      next_enable_b_reg  <= potc_pkg::NEXT_ENABLE_B_RST;
      trigger_select_reg <= potc_pkg::TRIGGER_SELECT_RST;
      overlap_mode_reg   <= potc_pkg::OVERLAP_MODE_RST[3:0];
      next_pattern_b_reg <= potc_pkg::NEXT_PATTERN_B_RST;
    end else if (hw_standby_s) begin
      next_enable_b_reg  <= potc_pkg::NEXT_ENABLE_B_RST;
      trigger_select_reg <= potc_pkg::TRIGGER_SELECT_RST;
      overlap_mode_reg   <= potc_pkg::OVERLAP_MODE_RST[3:0];
      next_pattern_b_reg <= potc_pkg::NEXT_PATTERN_B_RST;
    end else begin
      if (wr_en) next_enable_b_reg <= pwdata[7:0];
      if (wr_ts) trigger_select_reg <= pwdata[7:0];
      if (wr_om) overlap_mode_reg <= pwdata[3:0];
      if (wr_np) next_pattern_b_reg <= pwdata[7:0];
    end
  end

  // upper half groups 3 and 2 steer port B; lower groups only report their events
  for (genvar g = 0; g < potc_pkg::NUM_CH; g++) begin : g_grp
    logic [potc_pkg::SEL_W-1:0] sel_w;
    logic [potc_pkg::GRP_W-1:0] en_w;
    logic [potc_pkg::GRP_W-1:0] pat_w;
    logic [potc_pkg::GRP_W-1:0] cur_w;
    logic [potc_pkg::GRP_W-1:0] nxt_w;
    assign sel_w = trigger_select_reg[g*potc_pkg::SEL_W +: potc_pkg::SEL_W];
    if (g >= potc_pkg::GRP_BASE) begin : g_port
      localparam int LSB = (g - potc_pkg::GRP_BASE) * potc_pkg::GRP_W;
      assign en_w  = next_enable_b_reg[LSB +: potc_pkg::GRP_W];
      assign pat_w = next_pattern_b_reg[LSB +: potc_pkg::GRP_W];
      assign cur_w = port_b_base[LSB +: potc_pkg::GRP_W];
      assign port_b_output_next[LSB +: potc_pkg::GRP_W] = nxt_w;
    end else begin : g_quiet
      // the lower port lives outside this block, so these groups copy nothing
      assign en_w  = '0;
      assign pat_w = '0;
      assign cur_w = '0;
    end
    potc_group u_grp (
      .nonoverlap (overlap_mode_reg[g]),
      .sel        (sel_w),
      .evt        (tmr_evt),
      .enable     (en_w),
      .pattern    (pat_w),
      .cur        (cur_w),
      .nxt        (nxt_w),
      .fire_a     (fire_a_all[g]),
      .fire_b     (fire_b_all[g])
    );
  end

  // a timer copy beats a software write to the same port bit in one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_output_reg <= potc_pkg::PORT_B_OUTPUT_RST;
    end else begin
      port_b_output_reg <= port_b_output_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      grp_trig_a <= 4'h0;
      grp_trig_b <= 4'h0;
    end else begin
      grp_trig_a <= fire_a_all;
      grp_trig_b <= fire_b_all;
    end
  end
  assign port_b_output = port_b_output_reg;

  property p_copy_next_edge;
    @(posedge mclk) disable iff (!rst_n)
      (fire_a_all[3] && next_enable_b_reg[7] && !hw_standby_s)
        |=> port_b_output_reg[7] == $past(next_pattern_b_reg[7]);
  endproperty
  a_copy_next_edge: assert property (p_copy_next_edge)
    else $error("enabled bit not copied at event");

  property p_disabled_holds;
    @(posedge mclk) disable iff (!rst_n)
      (!next_enable_b_reg[0] && !wr_po) |=> $stable(port_b_output_reg[0]);
  endproperty
  a_disabled_holds: assert property (p_disabled_holds) else $error("disabled bit changed");

  property p_nov_b_zero_only;
    @(posedge mclk) disable iff (!rst_n)
      (overlap_mode_reg[2] && fire_b_all[2] && !fire_a_all[2] && !wr_po)
        |=> !($rose(port_b_output_reg[0]));
  endproperty
  a_nov_b_zero_only: assert property (p_nov_b_zero_only) else $error("B event set a one");

  property p_rsvd_read;
    @(posedge mclk) disable iff (!rst_n)
      (access_w && !pwrite && hit_om) |=> prdata[7:4] == 4'hf;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not read as one");

  property p_standby_init;
    @(posedge mclk) disable iff (!rst_n)
      hw_standby_s |=> (next_enable_b_reg == 8'h00 && trigger_select_reg == 8'hff
                        && overlap_mode_reg == 4'h0);
  endproperty
  a_standby_init: assert property (p_standby_init) else $error("standby init wrong");

  property p_normal_ignores_b;
    @(posedge mclk) disable iff (!rst_n)
      (!overlap_mode_reg[3] && !fire_a_all[3] && !wr_po) |=> $stable(port_b_output_reg[7:4]);
  endproperty
  a_normal_ignores_b: assert property (p_normal_ignores_b) else $error("normal mode moved off A");

  property p_answer_two;
    @(posedge mclk) disable iff (!rst_n)
      (psel && !penable && state_reg == potc_pkg::POTC_IDLE) ##1 (psel && penable) |=> pready;
  endproperty
  a_answer_two: assert property (p_answer_two) else $error("pready late");

  property p_sel_write;
    @(posedge mclk) disable iff (!rst_n)
      (wr_ts && !hw_standby_s) |=> trigger_select_reg[7:6] == $past(pwdata[7:6]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select bits not stored");

  // channel choice per group, each against the channel its select code names
  property p_g3_channel;
    @(posedge mclk) disable iff (!rst_n)
      (trigger_select_reg[7:6] == 2'h0 && !tmr_evt[0].capture_mode)
        |-> fire_a_all[3] == tmr_evt[0].cmp_a;
  endproperty
  a_g3_channel: assert property (p_g3_channel) else $error("group 3 on wrong channel");

  property p_g2_channel;
    @(posedge mclk) disable iff (!rst_n)
      (trigger_select_reg[5:4] == 2'h1 && !tmr_evt[1].capture_mode)
        |-> fire_a_all[2] == tmr_evt[1].cmp_a;
  endproperty
  a_g2_channel: assert property (p_g2_channel) else $error("group 2 on wrong channel");

  property p_g1_channel;
    @(posedge mclk) disable iff (!rst_n)
      (trigger_select_reg[3:2] == 2'h3 && !tmr_evt[3].capture_mode)
        |-> fire_a_all[1] == tmr_evt[3].cmp_a;
  endproperty
  a_g1_channel: assert property (p_g1_channel) else $error("group 1 on wrong channel");

  property p_g0_channel;
    @(posedge mclk) disable iff (!rst_n)
      (trigger_select_reg[1:0] == 2'h3 && !tmr_evt[3].capture_mode)
        |-> fire_b_all[0] == tmr_evt[3].cmp_b;
  endproperty
  a_g0_channel: assert property (p_g0_channel) else $error("group 0 on wrong channel");

  property p_capture_trig;
    @(posedge mclk) disable iff (!rst_n)
      (trigger_select_reg[7:6] == 2'h3 && tmr_evt[3].capture_mode)
        |-> fire_a_all[3] == tmr_evt[3].cap_a;
  endproperty
  a_capture_trig: assert property (p_capture_trig) else $error("capture not used");

  // copy paths of the two port groups
  property p_grp2_copy;
    @(posedge mclk) disable iff (!rst_n)
      (fire_a_all[2] && next_enable_b_reg[0])
        |=> port_b_output_reg[0] == $past(next_pattern_b_reg[0]);
  endproperty
  a_grp2_copy: assert property (p_grp2_copy) else $error("group 2 bit not copied");

  property p_nov_a_all;
    @(posedge mclk) disable iff (!rst_n)
      (overlap_mode_reg[3] && fire_a_all[3] && next_enable_b_reg[4])
        |=> port_b_output_reg[4] == $past(next_pattern_b_reg[4]);
  endproperty
  a_nov_a_all: assert property (p_nov_a_all) else $error("A event missed a bit");

  property p_nov_zero_at_b;
    @(posedge mclk) disable iff (!rst_n)
      (overlap_mode_reg[3] && fire_b_all[3] && next_enable_b_reg[6]
       && !next_pattern_b_reg[6])
        |=> !port_b_output_reg[6];
  endproperty
  a_nov_zero_at_b: assert property (p_nov_zero_at_b) else $error("B event missed a zero");

  // bus-side checks
  property p_strb_refused;
    @(posedge mclk) disable iff (!rst_n)
      (xfer_w && pwrite && !pstrb[0] && !hw_standby_s)
        |=> $stable(next_pattern_b_reg);
  endproperty
  a_strb_refused: assert property (p_strb_refused) else $error("lane 0 off but stored");

  property p_err_with_ready;
    @(posedge mclk) disable iff (!rst_n)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_rdata_quiet;
    @(posedge mclk) disable iff (!rst_n)
      !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside ready");

  property p_fsm_onehot;
    @(posedge mclk) disable iff (!rst_n)
      $onehot(state_reg);
  endproperty
  a_fsm_onehot: assert property (p_fsm_onehot) else $error("bus state not one-hot");

  property p_en_write;
    @(posedge mclk) disable iff (!rst_n)
      (wr_en && !hw_standby_s) |=> next_enable_b_reg == $past(pwdata[7:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write not stored");

  property p_mode_write;
    @(posedge mclk) disable iff (!rst_n)
      (wr_om && !hw_standby_s) |=> overlap_mode_reg == $past(pwdata[3:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write not stored");

endmodule // potc_top

// ===== hw/potc_pkg.sv
package potc_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_GRP = 2;
  localparam int GRP_W = 4;

  localparam logic [7:0] NEXT_ENABLE_B_RST = 8'h00;
  localparam logic [7:0] TRIGGER_SELECT_RST = 8'hff;
  localparam logic [7:0] OVERLAP_MODE_RST = 8'hf0;
  localparam logic [3:0] OVERLAP_RSVD_ONES = 4'hf;
  localparam logic [7:0] NEXT_PATTERN_B_RST = 8'h00;
  localparam logic [7:0] PORT_B_OUTPUT_RST = 8'h00;

  localparam logic [11:0] ADDR_NEXT_ENABLE_B = 12'h000;
  localparam logic [11:0] ADDR_TRIGGER_SELECT = 12'h004;
  localparam logic [11:0] ADDR_OVERLAP_MODE = 12'h008;
  localparam logic [11:0] ADDR_NEXT_PATTERN_B = 12'h00c;
  localparam logic [11:0] ADDR_PORT_B_OUTPUT = 12'h010;

  // two trigger-select bits per group, group g at bits 2g+1:2g
  localparam int SEL_W = 2;
  localparam int GRP_BASE = 2;

  // one timer channel's event pulses
  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic cap_a;
    logic cap_b;
    logic capture_mode;
  } potc_tmr_evt_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } potc_apb_req_type;

  typedef enum logic [2:0] {
    POTC_IDLE   = 3'b001,
    POTC_ACCESS = 3'b010,
    POTC_DONE   = 3'b100
  } potc_apb_state_type;

endpackage

// ===== hw/potc_sync2.sv
`timescale 1ns/1ps
module potc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // potc_sync2

// ===== hw/potc_group.sv
`timescale 1ns/1ps
module potc_group (
  input  wire logic                        nonoverlap,
  input  wire logic [1:0]                  sel,
  input  wire potc_pkg::potc_tmr_evt_type  evt [potc_pkg::NUM_CH],
  input  wire logic [potc_pkg::GRP_W-1:0]  enable,
  input  wire logic [potc_pkg::GRP_W-1:0]  pattern,
  input  wire logic [potc_pkg::GRP_W-1:0]  cur,
  output logic      [potc_pkg::GRP_W-1:0]  nxt,
  output logic                             fire_a,
  output logic                             fire_b
);
  potc_pkg::potc_tmr_evt_type ch;
  logic [potc_pkg::GRP_W-1:0] take_mask;

  assign ch = evt[sel];
  // capture replaces compare when the channel is in capture use
  assign fire_a = ch.capture_mode ? ch.cap_a : ch.cmp_a;
  assign fire_b = ch.capture_mode ? ch.cap_b : ch.cmp_b;
  // event A copies all enabled bits; event B only zeros in non-overlap
  assign take_mask = enable & ({potc_pkg::GRP_W{fire_a}}
                     | ({potc_pkg::GRP_W{fire_b & nonoverlap}} & ~pattern));
  assign nxt = (take_mask & pattern) | (~take_mask & cur);
endmodule // potc_group

// ===== tb/potc_timer_model.sv
`timescale 1ns/1ps
module potc_timer_model (
  input  wire logic                 mclk,
  output potc_pkg::potc_tmr_evt_type tmr_evt [potc_pkg::NUM_CH]
);
  initial begin
    for (int i = 0; i < potc_pkg::NUM_CH; i++) begin
      tmr_evt[i] = '0;
    end
  end

  // one-cycle pulse; k: 0 cmp_a, 1 cmp_b, 2 cap_a, 3 cap_b
  // period on B and margin on A, so t_nov issues B before A
  task automatic pulse(input int ch, input int k);
    @(posedge mclk);
    tmr_evt[ch][4-k] <= 1'b1;
    @(posedge mclk);
    tmr_evt[ch][4-k] <= 1'b0;
  endtask

  task automatic capmode(input int ch, input logic m);
    @(posedge mclk);
    tmr_evt[ch].capture_mode <= m;
  endtask
endmodule // potc_timer_model

// ===== tb/potc_top_bench.sv
`timescale 1ns/1ps
module potc_top_bench;
  logic        mclk, rst_n, hw_standby, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, grp_trig_a, grp_trig_b;
  logic [7:0]  port_b_output;
  potc_pkg::potc_tmr_evt_type tmr_evt [potc_pkg::NUM_CH];
  int          mismatches, compares;

  potc_top u_dut (.mclk(mclk), .rst_n(rst_n), .hw_standby(hw_standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr_evt(tmr_evt), .port_b_output(port_b_output),
    .grp_trig_a(grp_trig_a), .grp_trig_b(grp_trig_b));
  potc_timer_model u_tmr (.mclk(mclk), .tmr_evt(tmr_evt));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle count is assumed here; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    // taken at the edge that saw pready, before its update lands
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(rd, {24'h000000, x});
  endtask

  task automatic ev(input int ch, input int k, input logic [7:0] x);
    u_tmr.pulse(ch, k);
    #1;
    chk({24'h000000, port_b_output}, {24'h000000, x});
  endtask

  task automatic t_reset;
    rdc(potc_pkg::ADDR_NEXT_ENABLE_B, 8'h00);
    rdc(potc_pkg::ADDR_TRIGGER_SELECT, 8'hff);
    rdc(potc_pkg::ADDR_OVERLAP_MODE, 8'hf0);
    apb(1'b0, 12'h020, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
  endtask

  task automatic t_rsvd;
    pstrb <= 4'he;
    wr(potc_pkg::ADDR_NEXT_PATTERN_B, 8'h5a);
    pstrb <= 4'hf;
    rdc(potc_pkg::ADDR_NEXT_PATTERN_B, 8'h00);
    wr(potc_pkg::ADDR_OVERLAP_MODE, 8'h0f);
    rdc(potc_pkg::ADDR_OVERLAP_MODE, 8'hff);
    wr(potc_pkg::ADDR_OVERLAP_MODE, 8'h00);
    rdc(potc_pkg::ADDR_OVERLAP_MODE, 8'hf0);
  endtask

  task automatic t_sel;
    logic [1:0] c;
    wr(potc_pkg::ADDR_NEXT_ENABLE_B, 8'hff);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      // group 2 on the mirrored channel, so each pulse moves one nibble
      wr(potc_pkg::ADDR_TRIGGER_SELECT, {c, ~c, 4'hf});
      wr(potc_pkg::ADDR_PORT_B_OUTPUT, 8'h00);
      wr(potc_pkg::ADDR_NEXT_PATTERN_B, 8'hff);
      ev(i, 0, 8'hf0);
      ev(3 - i, 0, 8'hff);
    end
  endtask

  task automatic t_enable;
    wr(potc_pkg::ADDR_TRIGGER_SELECT, 8'hff);
    wr(potc_pkg::ADDR_NEXT_ENABLE_B, 8'h5a);
    wr(potc_pkg::ADDR_PORT_B_OUTPUT, 8'h00);
    wr(potc_pkg::ADDR_NEXT_PATTERN_B, 8'hff);
    ev(3, 0, 8'h5a);
    chk({24'h000000, grp_trig_a, grp_trig_b}, 32'h000000f0);
    wr(potc_pkg::ADDR_NEXT_PATTERN_B, 8'h00);
    ev(3, 1, 8'h5a);
    chk({24'h000000, grp_trig_a, grp_trig_b}, 32'h0000000f);
  endtask

  task automatic t_nov;
    wr(potc_pkg::ADDR_NEXT_ENABLE_B, 8'hff);
    wr(potc_pkg::ADDR_OVERLAP_MODE, 8'h0c);
    wr(potc_pkg::ADDR_PORT_B_OUTPUT, 8'h6a);
    wr(potc_pkg::ADDR_NEXT_PATTERN_B, 8'h95);
    ev(3, 1, 8'h00);
    ev(3, 0, 8'h95);
    wr(potc_pkg::ADDR_OVERLAP_MODE, 8'h00);
  endtask

  task automatic t_cap;
    wr(potc_pkg::ADDR_PORT_B_OUTPUT, 8'h00);
    wr(potc_pkg::ADDR_NEXT_PATTERN_B, 8'h3c);
    u_tmr.capmode(3, 1'b1);
    ev(3, 0, 8'h00);
    ev(3, 2, 8'h3c);
    u_tmr.capmode(3, 1'b0);
  endtask

  task automatic t_standby;
    wr(potc_pkg::ADDR_TRIGGER_SELECT, 8'h00);
    wr(potc_pkg::ADDR_OVERLAP_MODE, 8'h0f);
    @(posedge mclk);
    hw_standby <= 1'b1;
    repeat (6) @(posedge mclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(potc_pkg::ADDR_NEXT_ENABLE_B, 8'h00);
    rdc(potc_pkg::ADDR_TRIGGER_SELECT, 8'hff);
    rdc(potc_pkg::ADDR_OVERLAP_MODE, 8'hf0);
    chk({24'h000000, port_b_output}, 32'h0000003c);
  endtask

  task automatic test_done;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    hw_standby = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_rsvd();
    t_sel();
    t_enable();
    t_nov();
    t_cap();
    t_standby();
    test_done();
  end

  // the whole run takes a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule // potc_top_bench
